// file: core/atu_top.sv
// Summary of operation
// - an address hitting both block map and page lookaside uses the block map result
// - each side has four block map entries, all compared in parallel
// - each side has its own 64-entry two-way page lookaside
// - refill victim way is the least recently used way of the set
// - 4 KB pages in 256 MB segments; low 12 bits pass unchanged
// - block entries map 128 KB to 256 MB via a length mask
// - intermediate virtual address is 52 bits, physical address 32 bits
// - 32-bit effective addresses accepted from fetch and load/store paths
// - a miss is flagged at once; software searches tables and refills
// - every translation carries the write-through attribute of its entry
// - translated address feeds physically indexed and tagged cache lookup
module atu_top (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         sys_rst,
  // translation requests and answers, index 0 fetch, 1 data
  input  wire atu_pkg::atu_req_t [1:0]      xl_req,
  output wire atu_pkg::atu_rsp_t [1:0]      xl_rsp,
  output wire atu_pkg::atu_cache_look_t [1:0] cache_look,
  // software refill ports
  input  wire atu_pkg::atu_tlb_wr_t [1:0]   page_wr,
  input  wire atu_pkg::atu_blk_wr_t [1:0]   block_wr,
  input  wire atu_pkg::atu_seg_wr_t         seg_wr
);
  import atu_pkg::*;

  atu_core_st_t                     st_ff;
  atu_core_st_t                     nxt_st;
  logic [1:0][VSID_W-1:0]           seg_vsid;
  logic [1:0][VA_W-1:0]             va_c;
  atu_look_t [1:0]                  blk_c;
  atu_look_t [1:0]                  pg_c;
  logic [1:0][TLB_SET_W-1:0]        look_set;
  logic [1:0][TLB_SET_W-1:0]        fill_set;
  logic [1:0]                       fill_vic;

  ////////////////////////////////////////////////////////////////////////////
  // lookup functions

  // the segment number is swapped for its virtual segment id; the low 28 bits pass through
  function automatic logic [VA_W-1:0] form_va(logic [VSID_W-1:0] vsid, logic [EA_W-1:0] ea);
    return {vsid, ea[EA_W-SEG_IDX_W-1:0]};
  endfunction : form_va

  function automatic logic [TLB_SET_W-1:0] set_of(logic [EA_W-1:0] ea);
    return ea[PG_OFF_W+TLB_SET_W-1:PG_OFF_W];
  endfunction : set_of

  // lowest index wins when entries overlap
  function automatic atu_look_t blk_look(atu_blk_ent_t [BLK_N-1:0] arr, logic [EA_W-1:0] ea);
    atu_look_t            r;
    logic [BLK_EPI_W-1:0] msk;
    logic [BLK_EPI_W-1:0] epi;
    r   = '0;
    msk = '0;
    epi = ea[EA_W-1:BLK_OFF_W];
    for (int i = BLK_N - 1; i >= 0; i--) begin
      msk = {{(BLK_EPI_W-BLK_LEN_W){1'b0}}, arr[i].len_mask};
      if (arr[i].vld && (((epi ^ arr[i].epi) & ~msk) == '0)) begin
        r.hit = 1'b1;
        r.wt  = arr[i].wt;
        r.pa  = {(arr[i].rpn & ~msk) | (epi & msk), ea[BLK_OFF_W-1:0]};
      end
    end
    return r;
  endfunction : blk_look

  // way 0 wins if software leaves two matching tags in one set
  function automatic atu_look_t tlb_look(atu_tlb_ent_t [TLB_WAYS-1:0] set, logic [VA_W-1:0] va);
    atu_look_t r;
    r = '0;
    for (int w = TLB_WAYS - 1; w >= 0; w--) begin
      if (set[w].vld && set[w].tag == va[VA_W-1:PG_OFF_W+TLB_SET_W]) begin
        r.hit = 1'b1;
        r.way = 1'(w);
        r.wt  = set[w].wt;
        r.pa  = {set[w].rpn, va[PG_OFF_W-1:0]};
      end
    end
    return r;
  endfunction : tlb_look

  ////////////////////////////////////////////////////////////////////////////
  // segment registers, shared by both sides

  atu_seg_file u_seg (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .seg_wr   (seg_wr),
    .rd_seg   ({xl_req[SIDE_DATA].ea[EA_W-1:EA_W-SEG_IDX_W], xl_req[SIDE_FETCH].ea[EA_W-1:EA_W-SEG_IDX_W]}),
    .rd_vsid  (seg_vsid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // per-side lookup, both sides in parallel

  for (genvar s = 0; s < 2; s++) begin : g_side
    assign va_c[s]     = form_va(seg_vsid[s], xl_req[s].ea);
    // set index comes straight from the effective address, so it never waits on a segment read
    assign look_set[s] = set_of(xl_req[s].ea);
    assign blk_c[s]    = blk_look(st_ff.blk[s], xl_req[s].ea);
    assign pg_c[s]     = tlb_look(st_ff.tlb[s][look_set[s]], va_c[s]);
    assign fill_set[s] = set_of(page_wr[s].va[EA_W-1:0]);
    assign fill_vic[s] = st_ff.lru[s][fill_set[s]];
    assign xl_rsp[s]   = st_ff.rsp[s];
    assign cache_look[s].vld = st_ff.rsp[s].vld && !st_ff.rsp[s].miss;
    assign cache_look[s].idx = st_ff.rsp[s].pa[CLINE_W+CIDX_W-1:CLINE_W];
    assign cache_look[s].tag = st_ff.rsp[s].pa[PA_W-1:CLINE_W+CIDX_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st = st_ff;
    for (int s = 0; s < 2; s++) begin
      nxt_st.rsp[s] = '0;
      if (xl_req[s].vld) begin
        nxt_st.rsp[s].vld = 1'b1;
        nxt_st.rsp[s].va  = va_c[s];
        // a block hit leaves the order bits alone: only page ways are ever victims
        if (blk_c[s].hit) begin
          nxt_st.rsp[s].from_block = 1'b1;
          nxt_st.rsp[s].write_thru = blk_c[s].wt;
          nxt_st.rsp[s].pa         = blk_c[s].pa;
        end else if (pg_c[s].hit) begin
          nxt_st.rsp[s].write_thru     = pg_c[s].wt;
          nxt_st.rsp[s].pa             = pg_c[s].pa;
          nxt_st.lru[s][look_set[s]]   = ~pg_c[s].way;
        end else begin
          nxt_st.rsp[s].miss = 1'b1;
        end
      end
      // refill after the hit update, so a same-set refill owns the order bit
      if (page_wr[s].vld) begin
        nxt_st.tlb[s][fill_set[s]][fill_vic[s]].vld = 1'b1;
        nxt_st.tlb[s][fill_set[s]][fill_vic[s]].tag = page_wr[s].va[VA_W-1:PG_OFF_W+TLB_SET_W];
        nxt_st.tlb[s][fill_set[s]][fill_vic[s]].rpn = page_wr[s].rpn;
        nxt_st.tlb[s][fill_set[s]][fill_vic[s]].wt  = page_wr[s].wt;
        nxt_st.lru[s][fill_set[s]]                  = ~fill_vic[s];
      end
      if (block_wr[s].vld) begin
        nxt_st.blk[s][block_wr[s].idx] = block_wr[s].ent;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= ATU_CORE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  for (genvar s = 0; s < 2; s++) begin : g_chk
    sequence s_miss;
      xl_req[s].vld && !blk_c[s].hit && !pg_c[s].hit;
    endsequence
    sequence s_fill_then_look;
      (page_wr[s].vld && !block_wr[s].vld) ##1
      (xl_req[s].vld && !blk_c[s].hit && va_c[s][VA_W-1:PG_OFF_W] == $past(page_wr[s].va[VA_W-1:PG_OFF_W]));
    endsequence

    a_block_first: assert property (xl_req[s].vld && blk_c[s].hit |=>
      xl_rsp[s].from_block && xl_rsp[s].pa == $past(blk_c[s].pa))
      else $error("block map result not preferred");
    a_block_write: assert property (block_wr[s].vld |=>
      st_ff.blk[s][$past(block_wr[s].idx)] == $past(block_wr[s].ent))
      else $error("block map entry not written");
    a_fill_hits: assert property (s_fill_then_look |=>
      !xl_rsp[s].miss && xl_rsp[s].pa[PA_W-1:PG_OFF_W] == $past(page_wr[s].rpn, 2))
      else $error("refilled page does not translate");
    a_victim_lru: assert property (page_wr[s].vld |=>
      st_ff.tlb[s][$past(fill_set[s])][$past(fill_vic[s])].tag
        == $past(page_wr[s].va[VA_W-1:PG_OFF_W+TLB_SET_W])
      && st_ff.lru[s][$past(fill_set[s])] != $past(fill_vic[s]))
      else $error("refill not placed in least recent way");
    a_offset_pass: assert property (xl_rsp[s].vld && !xl_rsp[s].miss |->
      xl_rsp[s].pa[PG_OFF_W-1:0] == $past(xl_req[s].ea[PG_OFF_W-1:0]))
      else $error("page offset altered");
    a_block_size: assert property (xl_rsp[s].vld && xl_rsp[s].from_block |->
      xl_rsp[s].pa[BLK_OFF_W-1:0] == $past(xl_req[s].ea[BLK_OFF_W-1:0]))
      else $error("block offset altered");
    a_va_form: assert property (xl_req[s].vld |=>
      xl_rsp[s].va == {$past(seg_vsid[s]), $past(xl_req[s].ea[EA_W-SEG_IDX_W-1:0])})
      else $error("virtual address malformed");
    a_resp_timing: assert property (1'b1 |=> xl_rsp[s].vld == $past(xl_req[s].vld))
      else $error("answer not one cycle after request");
    a_miss_trap: assert property (s_miss |=> xl_rsp[s].miss && xl_rsp[s].pa == '0
      && !cache_look[s].vld)
      else $error("miss not flagged");
    a_write_attr: assert property (xl_req[s].vld && !blk_c[s].hit && pg_c[s].hit |=>
      xl_rsp[s].write_thru == $past(pg_c[s].wt) && !xl_rsp[s].from_block)
      else $error("write policy not taken from page");
    a_cache_feed: assert property (xl_rsp[s].vld && !xl_rsp[s].miss |->
      cache_look[s].vld && {cache_look[s].tag, cache_look[s].idx} == xl_rsp[s].pa[PA_W-1:CLINE_W])
      else $error("cache lookup not driven by physical address");

    // order bits: a page hit marks its way, a block hit touches nothing
    a_hit_marks: assert property (xl_req[s].vld && !blk_c[s].hit && pg_c[s].hit && !page_wr[s].vld |=>
      st_ff.lru[s][$past(look_set[s])] != $past(pg_c[s].way))
      else $error("page hit did not mark its way most recent");
    a_block_keeps_order: assert property (xl_req[s].vld && blk_c[s].hit && !page_wr[s].vld |=>
      st_ff.lru[s] == $past(st_ff.lru[s]))
      else $error("block hit disturbed the page order bits");
    a_hit_no_trap: assert property (xl_req[s].vld && (blk_c[s].hit || pg_c[s].hit) |=>
      !xl_rsp[s].miss)
      else $error("hit reported as a miss");
  end

  a_sides_parallel: assert property (xl_req[0].vld && xl_req[1].vld |=>
    xl_rsp[0].vld && xl_rsp[1].vld)
    else $error("sides not translated together");

endmodule : atu_top

// file: core/atu_pkg.sv
package atu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // address widths
  localparam int EA_W      = 32;
  localparam int PA_W      = 32;
  localparam int VA_W      = 52;
  localparam int VSID_W    = 24;
  localparam int SEG_IDX_W = 4;
  localparam int SEG_N     = 16;
  localparam int PG_OFF_W  = 12;
  localparam int RPN_W     = PA_W - PG_OFF_W;

  ////////////////////////////////////////////////////////////////////////////
  // page lookaside: 64 entries, two ways, 32 sets
  localparam int TLB_WAYS  = 2;
  localparam int TLB_SETS  = 32;
  localparam int TLB_SET_W = 5;
  localparam int TLB_TAG_W = VA_W - PG_OFF_W - TLB_SET_W;

  ////////////////////////////////////////////////////////////////////////////
  // block map array: four entries, 128 KB to 256 MB blocks
  localparam int BLK_N     = 4;
  localparam int BLK_IDX_W = 2;
  localparam int BLK_OFF_W = 17;
  localparam int BLK_EPI_W = EA_W - BLK_OFF_W;
  localparam int BLK_LEN_W = 11;

  ////////////////////////////////////////////////////////////////////////////
  // physically indexed cache: 16 KB, four ways, 32-byte lines, 128 sets
  localparam int CLINE_W   = 5;
  localparam int CIDX_W    = 7;
  localparam int CTAG_W    = PA_W - CLINE_W - CIDX_W;

  localparam int SIDE_FETCH = 0;
  localparam int SIDE_DATA  = 1;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic            vld;
    logic [EA_W-1:0] ea;
  } atu_req_t;

  typedef struct packed {
    logic            vld;
    logic            miss;
    logic            from_block;
    logic            write_thru;
    logic [VA_W-1:0] va;
    logic [PA_W-1:0] pa;
  } atu_rsp_t;

  typedef struct packed {
    logic              vld;
    logic [CIDX_W-1:0] idx;
    logic [CTAG_W-1:0] tag;
  } atu_cache_look_t;

  typedef struct packed {
    logic                 vld;
    logic [TLB_TAG_W-1:0] tag;
    logic [RPN_W-1:0]     rpn;
    logic                 wt;
  } atu_tlb_ent_t;

  typedef struct packed {
    logic             vld;
    logic [VA_W-1:0]  va;
    logic [RPN_W-1:0] rpn;
    logic             wt;
  } atu_tlb_wr_t;

  typedef struct packed {
    logic                 vld;
    logic [BLK_EPI_W-1:0] epi;
    logic [BLK_LEN_W-1:0] len_mask;
    logic [BLK_EPI_W-1:0] rpn;
    logic                 wt;
  } atu_blk_ent_t;

  typedef struct packed {
    logic                 vld;
    logic [BLK_IDX_W-1:0] idx;
    atu_blk_ent_t         ent;
  } atu_blk_wr_t;

  typedef struct packed {
    logic                 vld;
    logic [SEG_IDX_W-1:0] idx;
    logic [VSID_W-1:0]    vsid;
  } atu_seg_wr_t;

  typedef struct packed {
    logic            hit;
    logic            way;
    logic            wt;
    logic [PA_W-1:0] pa;
  } atu_look_t;

  typedef struct packed {
    atu_tlb_ent_t [1:0][TLB_SETS-1:0][TLB_WAYS-1:0] tlb;
    logic [1:0][TLB_SETS-1:0]                       lru;
    atu_blk_ent_t [1:0][BLK_N-1:0]                  blk;
    atu_rsp_t [1:0]                                 rsp;
  } atu_core_st_t;

  typedef struct packed {
    logic [SEG_N-1:0][VSID_W-1:0] vsid;
  } atu_seg_st_t;

  localparam atu_core_st_t ATU_CORE_RST = '0;
  localparam atu_seg_st_t  ATU_SEG_RST  = '0;

endpackage : atu_pkg

// file: core/atu_seg_file.sv
module atu_seg_file (
  // clock and reset
  input  wire logic                                   core_clk,
  input  wire logic                                   sys_rst,
  // segment write from software
  input  wire atu_pkg::atu_seg_wr_t                   seg_wr,
  // two read ports, one per translation side
  input  wire logic [1:0][atu_pkg::SEG_IDX_W-1:0]     rd_seg,
  output wire logic [1:0][atu_pkg::VSID_W-1:0]        rd_vsid
);
  import atu_pkg::*;

  atu_seg_st_t st_ff;
  atu_seg_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (seg_wr.vld) begin
      nxt_st.vsid[seg_wr.idx] = seg_wr.vsid;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= ATU_SEG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // read ports see the old value during a write to the same segment
  assign rd_vsid[0] = st_ff.vsid[rd_seg[0]];
  assign rd_vsid[1] = st_ff.vsid[rd_seg[1]];

endmodule : atu_seg_file

// file: test/atu_cpu_model.sv
module atu_cpu_model (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  // requests wanted by the bench, answers from the unit
  input  wire atu_pkg::atu_req_t [1:0] want,
  input  wire atu_pkg::atu_rsp_t [1:0] xl_rsp,
  output wire atu_pkg::atu_req_t [1:0] xl_req,
  output logic [1:0][15:0]             rsp_cnt_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  import atu_pkg::*;

  logic [1:0][EA_W-1:0] last_ea_ff = '0;

  ////////////////////////////////////////////////////////////
  // an idle address shows the inverse of its last value, so a stale address cannot hit by luck
  assign xl_req[0] = want[0].vld ? want[0] : {1'b0, ~last_ea_ff[0]};
  assign xl_req[1] = want[1].vld ? want[1] : {1'b0, ~last_ea_ff[1]};

  always @(posedge core_clk) begin
    for (int s = 0; s < 2; s++) begin
      if (want[s].vld) last_ea_ff[s] <= want[s].ea;
      if (sys_rst) rsp_cnt_ff[s] <= '0;
      else if (xl_rsp[s].vld) rsp_cnt_ff[s] <= rsp_cnt_ff[s] + 16'h0001;
    end
  end
endmodule : atu_cpu_model

// file: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import atu_pkg::*;

  typedef struct packed {
    logic            s;
    logic [EA_W-1:0] ea;
    logic            miss;
    logic            blk;
    logic            wt;
    logic [PA_W-1:0] pa;
  } atu_row_t;

  logic                  core_clk   = 1'b0;
  logic                  sys_rst    = 1'b1;
  atu_req_t [1:0]        want       = '0;
  atu_req_t [1:0]        xl_req;
  atu_rsp_t [1:0]        xl_rsp;
  atu_cache_look_t [1:0] cache_look;
  atu_tlb_wr_t [1:0]     page_wr    = '0;
  atu_blk_wr_t [1:0]     block_wr   = '0;
  atu_seg_wr_t           seg_wr     = '0;
  logic [1:0][15:0]      rsp_cnt;
  logic [VSID_W-1:0]     seg_vsid [SEG_N];
  atu_row_t              rows [7];
  int                    mismatches = 0;
  int                    tests_run  = 0;
  int                    sent       = 0;

  always #2.5 core_clk = ~core_clk;

  atu_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .xl_req(xl_req), .xl_rsp(xl_rsp),
               .cache_look(cache_look), .page_wr(page_wr), .block_wr(block_wr), .seg_wr(seg_wr));
  atu_cpu_model cpu (.core_clk(core_clk), .sys_rst(sys_rst), .want(want), .xl_rsp(xl_rsp),
                     .xl_req(xl_req), .rsp_cnt_ff(rsp_cnt));

  ////////////////////////////////////////////////////////////
  task automatic chk_flag(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  task automatic chk_addr(input string what, input logic [VA_W-1:0] exp, input logic [VA_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_addr

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic wr_seg(input logic [3:0] idx, input logic [VSID_W-1:0] vsid);
    seg_vsid[idx] = vsid;
    @(posedge core_clk);
    seg_wr <= {1'b1, idx, vsid};
    @(posedge core_clk);
    seg_wr <= '0;
  endtask : wr_seg

  task automatic wr_page(input int s, input logic [EA_W-1:0] ea, input logic [RPN_W-1:0] rpn, input logic wt);
    @(posedge core_clk);
    page_wr[s] <= {1'b1, seg_vsid[ea[31:28]], ea[27:0], rpn, wt};
    @(posedge core_clk);
    page_wr[s] <= '0;
  endtask : wr_page

  task automatic wr_blk(input int s, input logic [1:0] idx, input logic [14:0] epi, input logic [10:0] mask,
                        input logic [14:0] rpn, input logic wt);
    @(posedge core_clk);
    block_wr[s] <= {1'b1, idx, 1'b1, epi, mask, rpn, wt};
    @(posedge core_clk);
    block_wr[s] <= '0;
  endtask : wr_blk

  // one request per selected side, answers checked 1 ns after the taking edge
  task automatic send(input logic [1:0] on, input logic [EA_W-1:0] ea_f, input logic [EA_W-1:0] ea_d);
    @(posedge core_clk);
    want[0] <= {on[0], ea_f};
    want[1] <= {on[1], ea_d};
    sent += on[0] + on[1];
    @(posedge core_clk);
    want <= '0;
    #1;
  endtask : send

  task automatic check_rsp(input int s, input logic [EA_W-1:0] ea, input logic miss, input logic blk,
                           input logic wt, input logic [PA_W-1:0] pa);
    chk_flag("rsp.vld", 1'b1, xl_rsp[s].vld);
    chk_flag("rsp.miss", miss, xl_rsp[s].miss);
    chk_addr("rsp.va", {seg_vsid[ea[31:28]], ea[27:0]}, xl_rsp[s].va);
    chk_addr("rsp.pa", VA_W'(pa), VA_W'(xl_rsp[s].pa));
    chk_flag("cache_look.vld", !miss, cache_look[s].vld);
    if (!miss) begin
      chk_flag("rsp.from_block", blk, xl_rsp[s].from_block);
      chk_flag("rsp.write_thru", wt, xl_rsp[s].write_thru);
      chk_addr("cache_look", VA_W'(pa[31:5]), VA_W'({cache_look[s].tag, cache_look[s].idx}));
    end
  endtask : check_rsp

  ////////////////////////////////////////////////////////////
  initial begin
    rows[0] = {1'b0, 32'h1234_5678, 1'b0, 1'b0, 1'b1, 32'h5555_5678};
    rows[1] = {1'b1, 32'h1234_5678, 1'b1, 1'b0, 1'b0, 32'h0000_0000};
    rows[2] = {1'b1, 32'h8001_2345, 1'b0, 1'b1, 1'b0, 32'h2001_2345};
    rows[3] = {1'b1, 32'h8002_0000, 1'b1, 1'b0, 1'b0, 32'h0000_0000};
    rows[4] = {1'b1, 32'h9fff_fffc, 1'b0, 1'b1, 1'b1, 32'h1fff_fffc};
    rows[5] = {1'b0, 32'h8001_2345, 1'b1, 1'b0, 1'b0, 32'h0000_0000};
    rows[6] = {1'b0, 32'h0abc_d123, 1'b0, 1'b1, 1'b1, 32'heabc_d123};
    foreach (seg_vsid[i]) seg_vsid[i] = '0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk_flag("idle after reset", 1'b1, xl_rsp === '0 && cache_look === '0);
    wr_seg(4'h1, 24'h00_abcd);
    wr_page(0, 32'h1234_5678, 20'h5_5555, 1'b1);
    // a page under the block region, so the block result must win over it
    wr_page(1, 32'h8001_2345, 20'h7_7777, 1'b1);
    wr_blk(1, 2'h2, 15'h4000, 11'h000, 15'h1000, 1'b0);
    wr_blk(1, 2'h3, 15'h4800, 11'h7ff, 15'h0800, 1'b1);
    // the fetch side gets its own 256 MB block over segment 0
    wr_blk(0, 2'h0, 15'h0000, 11'h7ff, 15'h7000, 1'b1);
    foreach (rows[i]) begin
      send(rows[i].s ? 2'b10 : 2'b01, rows[i].ea, rows[i].ea);
      check_rsp(rows[i].s, rows[i].ea, rows[i].miss, rows[i].blk, rows[i].wt, rows[i].pa);
      @(posedge core_clk);
      #1;
      chk_flag("rsp one cycle", 1'b0, xl_rsp[rows[i].s].vld);
    end
    // three pages in set 5: the hit on the first one must steer the third refill onto the second
    wr_page(0, 32'h1236_5000, 20'h0_0b0b, 1'b0);
    send(2'b01, 32'h1234_5678, '0);
    wr_page(0, 32'h1238_5000, 20'h0_0c0c, 1'b0);
    send(2'b01, 32'h1234_5678, '0);
    check_rsp(0, 32'h1234_5678, 1'b0, 1'b0, 1'b1, 32'h5555_5678);
    send(2'b01, 32'h1236_5000, '0);
    check_rsp(0, 32'h1236_5000, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    send(2'b11, 32'h1238_5abc, 32'h9fff_fffc);
    check_rsp(0, 32'h1238_5abc, 1'b0, 1'b0, 1'b0, 32'h00c0_cabc);
    check_rsp(1, 32'h9fff_fffc, 1'b0, 1'b1, 1'b1, 32'h1fff_fffc);
    // refill and lookup on consecutive edges: the new entry must serve the very next request
    @(posedge core_clk);
    page_wr[1] <= {1'b1, seg_vsid[1], 28'h234_0000, 20'h0_0d0d, 1'b0};
    @(posedge core_clk);
    page_wr[1] <= '0;
    want[1]    <= {1'b1, 32'h1234_0010};
    sent++;
    @(posedge core_clk);
    want <= '0;
    #1;
    check_rsp(1, 32'h1234_0010, 1'b0, 1'b0, 1'b0, 32'h00d0_d010);
    // the model counts an answer at the edge after it appears
    @(posedge core_clk);
    #1;
    chk_addr("answers", VA_W'(sent), VA_W'(rsp_cnt[0] + rsp_cnt[1]));
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk_flag("idle in reset", 1'b1, xl_rsp === '0 && cache_look === '0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (seg_vsid[i]) seg_vsid[i] = '0;
    send(2'b01, 32'h1234_5678, '0);
    check_rsp(0, 32'h1234_5678, 1'b1, 1'b0, 1'b0, 32'h0000_0000);
    close_out();
  end

  // the sequence needs about sixty cycles
  initial begin
    repeat (2000) @(posedge core_clk);
    mismatches++;
    close_out();
  end
endmodule : tb
